// [design/mult24_params.svh]
// Offsets, field positions, reset values and constants of the multiplier
`ifndef MULT24_PARAMS_SVH
`define MULT24_PARAMS_SVH

// ==========================================================
// Register byte offsets
`define OFS_OPA     8'h00
`define OFS_OPB     8'h04
`define OFS_CTRL    8'h08
`define OFS_LOAD    8'h0c
`define OFS_PHIGH   8'h10
`define OFS_PLOW    8'h14
`define OFS_STATUS  8'h18
`define OFS_MASK    8'h1c

// ==========================================================
// Field positions and widths
`define OPW         24
`define PRW         48
`define CTRL_W      6
`define STAT_W      3
`define ST_DONE     0
`define ST_OVF      1
`define ST_CONFLICT 2
`define LOAD_BIT    0

// ==========================================================
// Rounding bit positions within the low half
`define RND_POS_A   23
`define RND_POS_B   22
`define RND_POS_C   21

// ==========================================================
// Reset values
`define CTRL_RST    6'h00
`define MASK_RST    3'h0
`define STAT_RST    3'h0

`endif

// [design/mult_pkg.sv]
// Types shared by the multiplier design
package mult_pkg;

  // ==========================================================
  // Rounding position select
  typedef enum logic [1:0] {
    RND_NONE,
    RND_BIT23,
    RND_BIT22,
    RND_BIT21
  } round_sel_type;

  // ==========================================================
  // Control register layout
  typedef struct packed {
    logic          oe_low;
    logic          oe_high;
    logic [1:0]    shift;
    round_sel_type rnd;
  } ctrl_type;

endpackage

// [design/registered_mult_24x24.sv]
// Registered 24x24 signed multiplier with APB register access
// Notes on behaviour
// RULE1 - Two operand registers load independently
// RULE2 - Operands are always two's-complement signed
// RULE3 - Full 48-bit product, split high/low
// RULE4 - Rounding adds one at bit 23/22/21
// RULE5 - Either half deliverable within one cycle
// RULE6 - Product registers load on separate strobe
// RULE7 - Separate output enables; one half per bus
// RULE8 - All registers capture on rising edge
// RULE9 - Output left shift by 0, 1, 2
// RULE10 - Overflow and normalization flags reported
// RULE11 - Overflow: lost bits; norm: top bits equal
// RULE12 - No round, no shift gives exact product
`timescale 1ns/1ps
`include "mult24_params.svh"

module registered_mult_24x24
  import mult_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Shared product port
  output logic      [23:0] prod_bus_out,
  output logic             prod_bus_oe,
  // Status
  output logic             ovf_flag,
  output logic             norm_flag,
  output logic             irq
);

  // ==========================================================
  // State
  logic [`OPW-1:0]    opa_reg;
  logic [`OPW-1:0]    opb_reg;
  ctrl_type           ctrl_reg;
  logic [`OPW-1:0]    phigh_reg;
  logic [`OPW-1:0]    plow_reg;
  logic               ovf_reg;
  logic               norm_reg;
  logic [`STAT_W-1:0] status_reg;
  logic [`STAT_W-1:0] status_next;
  logic [`STAT_W-1:0] mask_reg;
  logic [31:0]        prdata_reg;
  logic               pready_reg;
  logic               pslverr_reg;
  logic [23:0]        bus_out_reg;
  logic               bus_oe_reg;
  logic               irq_reg;

  // ==========================================================
  // APB decode
  logic access;
  logic wr;
  logic rd;
  logic mapped;
  logic wr_opa;
  logic wr_opb;
  logic wr_ctrl;
  logic wr_load;
  logic wr_mask;
  logic rd_status;
  logic [31:0] rd_mux;

  assign access    = psel & penable & pready_reg;
  assign wr        = access & pwrite;
  assign rd        = access & ~pwrite;
  assign wr_opa    = wr & (paddr == `OFS_OPA);
  assign wr_opb    = wr & (paddr == `OFS_OPB);
  assign wr_ctrl   = wr & (paddr == `OFS_CTRL);
  assign wr_load   = wr & (paddr == `OFS_LOAD) & pwdata[`LOAD_BIT];
  assign wr_mask   = wr & (paddr == `OFS_MASK);
  assign rd_status = rd & (paddr == `OFS_STATUS);

  always_comb
  begin
    mapped = 1'b1;
    rd_mux = 32'h0;
    unique case (paddr)
      `OFS_OPA:    rd_mux = {8'h0, opa_reg};
      `OFS_OPB:    rd_mux = {8'h0, opb_reg};
      `OFS_CTRL:   rd_mux = {26'h0, ctrl_reg};
      `OFS_LOAD:   rd_mux = 32'h0;
      `OFS_PHIGH:  rd_mux = {8'h0, phigh_reg};
      `OFS_PLOW:   rd_mux = {8'h0, plow_reg};
      `OFS_STATUS: rd_mux = {29'h0, status_reg};
      `OFS_MASK:   rd_mux = {29'h0, mask_reg};
      default:     mapped = 1'b0;
    endcase
  end

  // One wait state; read data is sampled in the first access cycle
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0;
    end
    else
    begin
      pready_reg  <= psel & penable & ~pready_reg;
      pslverr_reg <= psel & penable & ~pready_reg & ~mapped;
      if (psel & penable & ~pready_reg)
        prdata_reg <= pwrite ? 32'h0 : rd_mux;
    end
  end

  // ==========================================================
  // Operand registers, each with its own load strobe
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      opa_reg <= '0;
    else if (wr_opa)
      opa_reg <= pwdata[`OPW-1:0]; // RULE1 RULE8
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      opb_reg <= '0;
    else if (wr_opb)
      opb_reg <= pwdata[`OPW-1:0]; // RULE1 RULE8
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ctrl_reg <= `CTRL_RST;
      mask_reg <= `MASK_RST;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_reg <= pwdata[`CTRL_W-1:0];
      if (wr_mask)
        mask_reg <= pwdata[`STAT_W-1:0];
    end
  end

  // ==========================================================
  // Product datapath
  logic signed [`PRW-1:0] prod_raw;
  logic        [`PRW-1:0] round_add;
  logic        [`PRW-1:0] rounded;
  logic        [`PRW-1:0] shifted;
  logic        [1:0]      sh_amt;
  logic                   ovf_calc;

  assign prod_raw = $signed(opa_reg) * $signed(opb_reg); // RULE2 RULE3

  always_comb
  begin
    unique case (ctrl_reg.rnd)
      RND_NONE:  round_add = '0; // RULE12
      RND_BIT23: round_add = 48'h1 << `RND_POS_A; // RULE4
      RND_BIT22: round_add = 48'h1 << `RND_POS_B; // RULE4
      RND_BIT21: round_add = 48'h1 << `RND_POS_C; // RULE4
    endcase
  end

  // Largest magnitude product is 2^46, so the round add cannot wrap
  assign rounded = prod_raw + round_add;
  // Shift code 3 is treated as a shift of two
  assign sh_amt  = (ctrl_reg.shift == 2'd3) ? 2'd2 : ctrl_reg.shift;
  assign shifted = rounded << sh_amt; // RULE9

  always_comb
  begin
    unique case (sh_amt)
      2'd1:    ovf_calc = rounded[47] ^ rounded[46]; // RULE11
      2'd2:    ovf_calc = ~((rounded[47:45] == 3'b000) |
                            (rounded[47:45] == 3'b111)); // RULE11
      default: ovf_calc = 1'b0;
    endcase
  end

  // Product registers load together on their own strobe
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      phigh_reg <= '0;
      plow_reg  <= '0;
      ovf_reg   <= 1'b0;
      norm_reg  <= 1'b0;
    end
    else if (wr_load)
    begin
      phigh_reg <= shifted[`PRW-1:`OPW]; // RULE3 RULE6 RULE8
      plow_reg  <= shifted[`OPW-1:0]; // RULE3 RULE6
      ovf_reg   <= ovf_calc; // RULE10
      norm_reg  <= shifted[47] == shifted[46]; // RULE10 RULE11
    end
  end

  // ==========================================================
  // Shared output port; high half wins if both enables are set
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      bus_out_reg <= '0;
      bus_oe_reg  <= 1'b0;
    end
    else
    begin
      bus_out_reg <= ctrl_reg.oe_high ? phigh_reg : plow_reg; // RULE5 RULE7
      bus_oe_reg  <= ctrl_reg.oe_high | ctrl_reg.oe_low; // RULE7
    end
  end

  // ==========================================================
  // Sticky status, cleared by reading only the bits returned
  always_comb
  begin
    status_next = status_reg;
    if (rd_status)
      status_next = status_reg & ~prdata_reg[`STAT_W-1:0];
    if (wr_load)
    begin
      status_next[`ST_DONE] = 1'b1;
      if (ovf_calc)
        status_next[`ST_OVF] = 1'b1;
    end
    if (wr_ctrl & pwdata[4] & pwdata[5])
      status_next[`ST_CONFLICT] = 1'b1; // RULE7
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      status_reg <= `STAT_RST;
      irq_reg    <= 1'b0;
    end
    else
    begin
      status_reg <= status_next;
      irq_reg    <= |(status_reg & mask_reg);
    end
  end

  // ==========================================================
  // Outputs
  assign prdata       = prdata_reg;
  assign pready       = pready_reg;
  assign pslverr      = pslverr_reg;
  assign prod_bus_out = bus_out_reg;
  assign prod_bus_oe  = bus_oe_reg;
  assign ovf_flag     = ovf_reg;
  assign norm_flag    = norm_reg;
  assign irq          = irq_reg;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  opa_load_a: assert property (wr_opa |=> // RULE1
    opa_reg == $past(pwdata[23:0]) && $stable(opb_reg))
    else $error("operand A load wrong or disturbed B");

  opb_load_a: assert property (wr_opb |=> // RULE1
    opb_reg == $past(pwdata[23:0]) && $stable(opa_reg))
    else $error("operand B load wrong or disturbed A");

  exact_prod_a: assert property (wr_load && ctrl_reg == '0 |=> // RULE12
    {phigh_reg, plow_reg} ==
    $past({{24{opa_reg[23]}}, opa_reg} * {{24{opb_reg[23]}}, opb_reg}))
    else $error("unrounded product is not exact");

  round_pos_a: assert property (wr_load && ctrl_reg.shift == 2'd0 &&
    ctrl_reg.rnd == RND_BIT22 |=> // RULE4
    {phigh_reg, plow_reg} ==
    $past(prod_raw) + 48'h000000400000)
    else $error("rounding at bit 22 wrong");

  shift_two_a: assert property (wr_load && ctrl_reg.rnd == RND_NONE &&
    ctrl_reg.shift == 2'd2 |=> // RULE9
    {phigh_reg, plow_reg} == {$past(prod_raw[45:0]), 2'b00})
    else $error("shift by two wrong");

  ovf_flag_a: assert property (wr_load && ctrl_reg.rnd == RND_NONE &&
    ctrl_reg.shift == 2'd1 |=> // RULE11
    ovf_reg == ($past(prod_raw[47]) != $past(prod_raw[46])))
    else $error("overflow flag wrong");

  prod_hold_a: assert property (!wr_load |=> // RULE6
    $stable(phigh_reg) && $stable(plow_reg) && $stable(norm_reg))
    else $error("product changed without load");

  bus_half_a: assert property (ctrl_reg.oe_low && !ctrl_reg.oe_high
    |=> prod_bus_oe && prod_bus_out == $past(plow_reg)) // RULE7
    else $error("low half not on shared port");

  norm_flag_a: assert property (wr_load |=> // RULE10
    norm_flag == (phigh_reg[23] == phigh_reg[22]))
    else $error("normalization flag wrong");

  irq_level_a: assert property (##1 irq == // RULE10
    |($past(status_reg) & $past(mask_reg)))
    else $error("interrupt level wrong");

endmodule // registered_mult_24x24

// [test/sys_bus_model.sv]
// Model of the shared system bus on the product port
`timescale 1ns/1ps
module sys_bus_model
(
  // Clock
  input  wire logic        clk,
  // Product port
  input  wire logic [23:0] prod_bus_out,
  input  wire logic        prod_bus_oe,
  // Resolved bus
  output logic      [23:0] sys_bus
);
  logic [23:0] last_reg;

  always_ff @(posedge clk)
  begin
    if (prod_bus_oe)
      last_reg <= prod_bus_out;
  end

  // Released bus shows the inverse of the last word driven
  assign sys_bus = prod_bus_oe ? prod_bus_out : ~last_reg;
endmodule // sys_bus_model

// [test/tb_top.sv]
// Self-checking testbench for the registered multiplier
`timescale 1ns/1ps
`include "mult24_params.svh"
module tb_top;
  logic        clk, sys_rst, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, oe, ovf, nrm, irq, err;
  logic [23:0] pbus, sbus;
  logic [47:0] p;
  int          fail_count, num_checks;

  registered_mult_24x24 i_registered_mult_24x24
  (
    .clk(clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .prod_bus_out(pbus), .prod_bus_oe(oe), .ovf_flag(ovf),
    .norm_flag(nrm), .irq(irq)
  );

  sys_bus_model i_sys_bus_model
  (
    .clk(clk), .prod_bus_out(pbus), .prod_bus_oe(oe), .sys_bus(sbus)
  );

  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [47:0] g, input logic [47:0] e);
    num_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic results;
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n == 20)
    begin
      fail_count++;
      results();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic ld(input logic [23:0] a, input logic [23:0] b,
                    input logic [5:0] c);
    apb(1'b1, `OFS_OPA, {8'h00, a});
    apb(1'b1, `OFS_OPB, {8'h00, b});
    apb(1'b1, `OFS_CTRL, {26'h0, c});
    apb(1'b1, `OFS_LOAD, 32'h1);
  endtask

  task automatic rdp;
    apb(1'b0, `OFS_PHIGH, 32'h0);
    p[47:24] = rd[23:0];
    apb(1'b0, `OFS_PLOW, 32'h0);
    p[23:0] = rd[23:0];
  endtask

  task automatic pause;
    repeat (2) @(posedge clk);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset;
    logic [7:0] ra [3];
    ra = '{`OFS_CTRL, `OFS_MASK, `OFS_STATUS};
    foreach (ra[i])
    begin
      apb(1'b0, ra[i], 32'h0);
      chk(48'(rd), 48'h0);
    end
    apb(1'b0, 8'h20, 32'h0);
    chk(48'({err, rd}), 48'h100000000);
  endtask

  task automatic t_exact;
    ld(24'hfffffd, 24'h000005, 6'h00);
    rdp();
    chk(p, 48'hfffffffffff1);
    chk(48'(nrm), 48'h1);
  endtask

  task automatic t_round;
    for (int r = 1; r < 4; r++)
    begin
      ld(24'h000001, 24'h000001, 6'(r));
      rdp();
      chk(p, 48'h1 + (48'h1 << (24 - r)));
    end
  endtask

  task automatic t_shift;
    for (int s = 0; s < 3; s++)
    begin
      ld(24'h000001, 24'h000001, 6'(s << 2));
      rdp();
      chk(p, 48'h1 << s);
      chk(48'({ovf, nrm}), 48'h1);
    end
    ld(24'h800000, 24'h800000, 6'h04);
    rdp();
    chk(p, 48'h800000000000);
    chk(48'({ovf, nrm}), 48'h2);
    ld(24'h7fffff, 24'h7fffff, 6'h0c);
    rdp();
    chk(p, 48'hfffffc000004);
    chk(48'({ovf, nrm}), 48'h3);
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk(48'(rd), 48'h3);
  endtask

  task automatic t_indep;
    ld(24'h000002, 24'h000003, 6'h00);
    apb(1'b1, `OFS_OPB, 32'h7);
    apb(1'b1, `OFS_LOAD, 32'h0);
    apb(1'b1, `OFS_PLOW, 32'h55);
    rdp();
    chk(p, 48'h6);
    apb(1'b1, `OFS_LOAD, 32'h1);
    rdp();
    chk(p, 48'he);
  endtask

  task automatic t_port;
    apb(1'b1, `OFS_CTRL, 32'h10);
    pause();
    chk(48'({oe, sbus}), 48'h1000000);
    apb(1'b1, `OFS_CTRL, 32'h20);
    pause();
    chk(48'({oe, sbus}), 48'h100000e);
    apb(1'b1, `OFS_CTRL, 32'h30);
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk(48'(rd), 48'h5);
    apb(1'b1, `OFS_CTRL, 32'h0);
    pause();
    chk(48'(oe), 48'h0);
  endtask

  task automatic t_irq;
    apb(1'b1, `OFS_MASK, 32'h1);
    apb(1'b1, `OFS_LOAD, 32'h1);
    pause();
    chk(48'(irq), 48'h1);
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk(48'(rd), 48'h1);
    pause();
    chk(48'(irq), 48'h0);
    apb(1'b1, `OFS_MASK, 32'h0);
    apb(1'b1, `OFS_LOAD, 32'h1);
    pause();
    chk(48'(irq), 48'h0);
  endtask

  // ==========================================================
  // Clock and main sequence
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial
  begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    fail_count = 0;
    num_checks = 0;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_exact();
    t_round();
    t_shift();
    t_indep();
    t_port();
    t_irq();
    results();
  end
endmodule // tb_top
